// ### common/seq_xfer_pkg.sv
package seq_xfer_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_SEQ = 8'h00;
	localparam logic [7:0] ADDR_XA = 8'h01;
	localparam logic [7:0] ADDR_XB = 8'h02;
	// sequence_control fields
	localparam int SEQ_TROLE = 7;
	localparam int SEQ_SELO = 6;
	localparam int SEQ_SELI = 5;
	localparam int SEQ_RSELI = 4;
	localparam int SEQ_AAO = 3;
	localparam int SEQ_AAI = 2;
	localparam int SEQ_AAP = 1;
	localparam int SEQ_RSTO = 0;
	// transfer_control_a fields
	localparam int XA_FON = 7;
	localparam int XA_FEXP = 6;
	localparam int XA_CLRCNT = 4;
	localparam int XA_PIO = 3;
	localparam int XA_CFG = 2;
	localparam int XA_CLRCHN = 1;
	localparam logic [7:0] XA_STORE_MASK = 8'hcc;
	// transfer_control_b fields
	localparam int XB_PCHK = 5;
	localparam int XB_TSEL_HI = 4;
	localparam int XB_TSEL_LO = 3;
	localparam int XB_TMR = 2;
	// Reset values
	localparam logic [7:0] SEQ_RESET = 8'h00;
	localparam logic [7:0] XA_RESET = 8'h00;
	localparam logic [7:0] XB_RESET = 8'h00;
	// Timing, in picoseconds
	localparam int CLK_PS = 25000;
	localparam int FILT_FAST_MAX_PS = 25000;
	localparam int FILT_SLOW_MAX_PS = 62500;
	localparam int FILT_EXP_MAX_PS = 75000;
	localparam logic [1:0] FILT_FAST_CYC = 2'(FILT_FAST_MAX_PS / CLK_PS);
	localparam logic [1:0] FILT_SLOW_CYC = 2'(FILT_SLOW_MAX_PS / CLK_PS);
	localparam logic [1:0] FILT_EXP_CYC = 2'(FILT_EXP_MAX_PS / CLK_PS);
	// Shortest selection timeout in ms, and its cycle count at 40 MHz
	localparam int SEL_TO_MIN_MS = 32;
	localparam int SEL_TO_MIN_CYC = SEL_TO_MIN_MS * 40000;
	localparam int SYNC_W = 7;

	typedef struct packed {
		logic bsy;
		logic sel;
		logic atn;
		logic rst;
	} bus_out_t;

	typedef struct packed {
		logic sel_in_progress;
		logic sel_done;
		logic sel_timeout;
		logic selected_in;
		logic target_role;
	} status_t;

	typedef enum logic [2:0] {
		SO_IDLE = 3'b000,
		SO_ARB = 3'b001,
		SO_SEL = 3'b011,
		SO_DONE = 3'b010,
		SO_TMO = 3'b110
	} sel_state_t;
endpackage

// ### core/seq_xfer_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module seq_xfer_ctl #(
	parameter int ARB_CYCLES = 96,
	parameter int SEL_TO_BASE = seq_xfer_pkg::SEL_TO_MIN_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	input wire logic i_latch_wr,
	input wire logic i_latch_rd,
	output logic [7:0] o_latch_data,
	input wire logic i_clear_attention,
	input wire seq_xfer_pkg::status_t i_status_clear,
	input wire logic i_rate_slow,
	input wire logic i_bus_dma_enable,
	input wire logic i_bus_transfer_enable,
	input wire logic i_parity_err,
	input wire logic i_phase_in,
	input wire seq_xfer_pkg::bus_out_t i_direct,
	input wire logic i_bus_bsy,
	input wire logic i_bus_sel,
	input wire logic i_bus_req,
	input wire logic i_bus_ack,
	input wire logic i_bus_rst,
	input wire logic i_sel_valid,
	input wire logic i_resel_valid,
	output seq_xfer_pkg::bus_out_t o_bus,
	output logic o_req_filt,
	output logic o_ack_filt,
	output seq_xfer_pkg::status_t o_status,
	output logic o_pio_start,
	output logic o_clear_count,
	output logic o_clear_channel,
	output logic o_event_timer_en
);
	logic [7:0] sequence_control;
	logic [7:0] transfer_control_a;
	logic [7:0] transfer_control_b;
	logic [seq_xfer_pkg::SYNC_W-1:0] s1, s2, s3, lvl, lvl_d;
	logic bsy_l, sel_l, req_l, ack_l, brst_l;
	logic sel_rise, resel_rise, brst_rise, bus_free;
	seq_xfer_pkg::sel_state_t state;
	logic [23:0] tmr;
	logic [23:0] to_limit;
	logic [7:0] arb_cnt;
	logic atn_auto;
	logic tmo_rst;
	logic [1:0] flen;
	logic [1:0] fcnt [2];
	logic [1:0] fin, fout;
	logic wr_seq, wr_xa, wr_xb;
	logic pio_ok;

	assign wr_seq = i_ce && i_reg_wr && (i_reg_addr == seq_xfer_pkg::ADDR_SEQ);
	assign wr_xa = i_ce && i_reg_wr && (i_reg_addr == seq_xfer_pkg::ADDR_XA);
	assign wr_xb = i_ce && i_reg_wr && (i_reg_addr == seq_xfer_pkg::ADDR_XB);

	// Three-stage synchroniser; a level counts once stages two and three agree
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			lvl <= '0;
			lvl_d <= '0;
		end else if (i_ce) begin
			s1 <= {i_resel_valid, i_sel_valid, i_bus_rst, i_bus_ack, i_bus_req, i_bus_sel, i_bus_bsy};
			s2 <= s1;
			s3 <= s2;
			lvl <= (s2 & s3) | (lvl & (s2 | s3));
			lvl_d <= lvl;
		end
	end

	assign bsy_l = lvl[0];
	assign sel_l = lvl[1];
	assign req_l = lvl[2];
	assign ack_l = lvl[3];
	assign brst_l = lvl[4];
	assign sel_rise = lvl[5] & ~lvl_d[5];
	assign resel_rise = lvl[6] & ~lvl_d[6];
	assign brst_rise = brst_l & ~lvl_d[4];
	assign bus_free = ~bsy_l & ~sel_l;

	// Sequence control register; bus reset spares only the reset-out bit
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sequence_control <= seq_xfer_pkg::SEQ_RESET;
		end else if (i_ce) begin
			if (brst_l) begin
				sequence_control <= {7'h00, sequence_control[seq_xfer_pkg::SEQ_RSTO]};
			end else if (wr_seq) begin
				sequence_control <= i_reg_wdata;
			end
		end
	end

	// Transfer control registers; one-shot bits are never stored
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			transfer_control_a <= seq_xfer_pkg::XA_RESET;
			transfer_control_b <= seq_xfer_pkg::XB_RESET;
		end else if (i_ce) begin
			if (wr_xa) begin
				transfer_control_a <= i_reg_wdata & seq_xfer_pkg::XA_STORE_MASK;
			end
			if (wr_xb) begin
				transfer_control_b <= i_reg_wdata;
			end
		end
	end

	// One-cycle strobes for counter and channel clears
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_clear_count <= 1'b0;
			o_clear_channel <= 1'b0;
		end else if (i_ce) begin
			o_clear_count <= wr_xa && i_reg_wdata[seq_xfer_pkg::XA_CLRCNT];
			o_clear_channel <= wr_xa && i_reg_wdata[seq_xfer_pkg::XA_CLRCHN];
		end
	end

	// Register read port
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_ce && i_reg_rd) begin
			case (i_reg_addr)
				seq_xfer_pkg::ADDR_SEQ: o_reg_rdata <= sequence_control;
				seq_xfer_pkg::ADDR_XA: o_reg_rdata <= transfer_control_a;
				seq_xfer_pkg::ADDR_XB: o_reg_rdata <= transfer_control_b;
				default: o_reg_rdata <= 8'h00;
			endcase
		end
	end

	// Selection timeout limit from the select field
	always_comb begin
		case (transfer_control_b[seq_xfer_pkg::XB_TSEL_HI:seq_xfer_pkg::XB_TSEL_LO])
			2'b00: to_limit = 24'(SEL_TO_BASE * 8);
			2'b01: to_limit = 24'(SEL_TO_BASE * 4);
			2'b10: to_limit = 24'(SEL_TO_BASE * 2);
			default: to_limit = 24'(SEL_TO_BASE);
		endcase
	end

	// Outbound selection and reselection sequencer
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= seq_xfer_pkg::SO_IDLE;
			tmr <= 24'h000000;
			arb_cnt <= 8'h00;
		end else if (i_ce) begin
			if (!sequence_control[seq_xfer_pkg::SEQ_SELO]) begin
				state <= seq_xfer_pkg::SO_IDLE;
				tmr <= 24'h000000;
				arb_cnt <= 8'h00;
			end else begin
				case (state)
					seq_xfer_pkg::SO_IDLE: begin
						if (bus_free) begin
							state <= seq_xfer_pkg::SO_ARB;
						end
					end
					seq_xfer_pkg::SO_ARB: begin
						arb_cnt <= arb_cnt + 8'h01;
						if (arb_cnt == 8'(ARB_CYCLES - 1)) begin
							state <= seq_xfer_pkg::SO_SEL;
							tmr <= 24'h000000;
						end
					end
					seq_xfer_pkg::SO_SEL: begin
						if (bsy_l) begin
							state <= seq_xfer_pkg::SO_DONE;
						end else if (transfer_control_b[seq_xfer_pkg::XB_TMR]) begin
							tmr <= tmr + 24'h000001;
							if (tmr == to_limit - 24'h000001) begin
								state <= seq_xfer_pkg::SO_TMO;
							end
						end
					end
					seq_xfer_pkg::SO_DONE: state <= seq_xfer_pkg::SO_DONE;
					seq_xfer_pkg::SO_TMO: state <= seq_xfer_pkg::SO_TMO;
					default: state <= seq_xfer_pkg::SO_IDLE;
				endcase
			end
		end
	end

	// Status flags; a set in the cycle of a clear wins
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_status <= '0;
		end else if (i_ce) begin
			o_status.sel_in_progress <= (state == seq_xfer_pkg::SO_SEL) && !bsy_l;
			if (state == seq_xfer_pkg::SO_SEL && bsy_l) begin
				o_status.sel_done <= 1'b1;
			end else if (i_status_clear.sel_done) begin
				o_status.sel_done <= 1'b0;
			end
			if (state == seq_xfer_pkg::SO_SEL && !bsy_l && transfer_control_b[seq_xfer_pkg::XB_TMR]
				&& tmr == to_limit - 24'h000001) begin
				o_status.sel_timeout <= 1'b1;
			end else if (i_status_clear.sel_timeout) begin
				o_status.sel_timeout <= 1'b0;
			end
			if ((sel_rise && sequence_control[seq_xfer_pkg::SEQ_SELI])
				|| (resel_rise && sequence_control[seq_xfer_pkg::SEQ_RSELI])) begin
				o_status.selected_in <= 1'b1;
			end else if (i_status_clear.selected_in) begin
				o_status.selected_in <= 1'b0;
			end
			if (sel_rise && sequence_control[seq_xfer_pkg::SEQ_SELI]) begin
				o_status.target_role <= 1'b1;
			end else if (resel_rise && sequence_control[seq_xfer_pkg::SEQ_RSELI]) begin
				o_status.target_role <= 1'b0;
			end else if (state == seq_xfer_pkg::SO_SEL && bsy_l) begin
				o_status.target_role <= sequence_control[seq_xfer_pkg::SEQ_TROLE];
			end else if (i_status_clear.target_role) begin
				o_status.target_role <= 1'b0;
			end
		end
	end

	// Auto attention, held until clear-attention or bus free outside arbitration
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			atn_auto <= 1'b0;
		end else if (i_ce) begin
			if ((state == seq_xfer_pkg::SO_SEL && sequence_control[seq_xfer_pkg::SEQ_AAO]
				&& !sequence_control[seq_xfer_pkg::SEQ_TROLE])
				|| (resel_rise && sequence_control[seq_xfer_pkg::SEQ_RSELI]
				&& sequence_control[seq_xfer_pkg::SEQ_AAI])
				|| (i_parity_err && i_phase_in && !o_status.target_role
				&& sequence_control[seq_xfer_pkg::SEQ_AAP]
				&& transfer_control_b[seq_xfer_pkg::XB_PCHK])) begin
				atn_auto <= 1'b1;
			end else if (i_clear_attention || (bus_free && state != seq_xfer_pkg::SO_ARB)) begin
				atn_auto <= 1'b0;
			end
		end
	end

	// Bus reset after a selection timeout, unless auto-config is on
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			tmo_rst <= 1'b0;
		end else if (i_ce) begin
			tmo_rst <= (state == seq_xfer_pkg::SO_TMO) && !transfer_control_a[seq_xfer_pkg::XA_CFG];
		end
	end

	// Bus outputs; auto-config hands BSY and SEL to software, ATN and RST also take auto attention and reset-out
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_bus <= '0;
			o_event_timer_en <= 1'b0;
		end else if (i_ce) begin
			o_event_timer_en <= transfer_control_a[seq_xfer_pkg::XA_CFG];
			if (transfer_control_a[seq_xfer_pkg::XA_CFG]) begin
				o_bus.bsy <= i_direct.bsy;
				o_bus.sel <= i_direct.sel;
				o_bus.atn <= i_direct.atn | atn_auto;
				o_bus.rst <= i_direct.rst | sequence_control[seq_xfer_pkg::SEQ_RSTO];
			end else begin
				o_bus.bsy <= (state == seq_xfer_pkg::SO_ARB);
				o_bus.sel <= (state == seq_xfer_pkg::SO_SEL);
				o_bus.atn <= atn_auto;
				o_bus.rst <= sequence_control[seq_xfer_pkg::SEQ_RSTO] | tmo_rst;
			end
		end
	end

	// REQ/ACK filter length by rate and expand bit
	always_comb begin
		if (!i_rate_slow) begin
			flen = seq_xfer_pkg::FILT_FAST_CYC;
		end else if (transfer_control_a[seq_xfer_pkg::XA_FEXP]) begin
			flen = seq_xfer_pkg::FILT_EXP_CYC;
		end else begin
			flen = seq_xfer_pkg::FILT_SLOW_CYC;
		end
	end

	assign fin = {ack_l, req_l};

	// Change passes once the new level has held for the filter length
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			fout <= 2'b00;
			fcnt[0] <= 2'b00;
			fcnt[1] <= 2'b00;
		end else if (i_ce) begin
			for (int i = 0; i < 2; i++) begin
				if (!transfer_control_a[seq_xfer_pkg::XA_FON]) begin
					fout[i] <= fin[i];
					fcnt[i] <= 2'b00;
				end else if (fin[i] != fout[i]) begin
					if (fcnt[i] + 2'b01 >= flen) begin
						fout[i] <= fin[i];
						fcnt[i] <= 2'b00;
					end else begin
						fcnt[i] <= fcnt[i] + 2'b01;
					end
				end else begin
					fcnt[i] <= 2'b00;
				end
			end
		end
	end

	assign o_req_filt = fout[0];
	assign o_ack_filt = fout[1];

	// PIO only when neither DMA path owns the bus
	assign pio_ok = transfer_control_a[seq_xfer_pkg::XA_PIO] && !i_bus_dma_enable
		&& !i_bus_transfer_enable;

	// Data latch and PIO trigger; clear-channel drops a pending trigger
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_latch_data <= 8'h00;
			o_pio_start <= 1'b0;
		end else if (i_ce) begin
			if (i_latch_wr) begin
				o_latch_data <= i_reg_wdata;
			end
			o_pio_start <= pio_ok && (i_latch_wr || i_latch_rd) && !o_clear_channel;
		end
	end
endmodule
`default_nettype wire

// ### dv/bus_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_target_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_sel,
	input wire logic i_answer,
	input wire logic [3:0] i_delay,
	output logic o_bsy
);
	logic [3:0] wait_cnt;
	// Answers SEL with BSY after a chosen delay; released BSY is negated
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wait_cnt <= '0;
			o_bsy <= 1'b0;
		end else if (!i_answer) begin
			wait_cnt <= '0;
			o_bsy <= 1'b0;
		end else if (i_sel && !o_bsy) begin
			wait_cnt <= wait_cnt + 4'h1;
			if (wait_cnt == i_delay) o_bsy <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### dv/seq_xfer_ctl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module seq_xfer_ctl_checker (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_latch_wr,
	input wire logic i_latch_rd,
	input wire logic i_bus_dma_enable,
	input wire logic i_bus_transfer_enable,
	input wire seq_xfer_pkg::status_t i_status_clear,
	input wire seq_xfer_pkg::bus_out_t o_bus,
	input wire seq_xfer_pkg::status_t o_status,
	input wire logic o_pio_start,
	input wire logic o_clear_count,
	input wire logic o_clear_channel,
	input wire logic o_event_timer_en
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// Accepted write to control A
	sequence xa_wr;
		i_ce && i_reg_wr && i_reg_addr == seq_xfer_pkg::ADDR_XA;
	endsequence
	// Single-cycle strobe
	sequence one_pulse(sig);
		sig ##1 !sig;
	endsequence
	chk_clr_count_pulse: assert property (xa_wr ##0 i_reg_wdata[4] |=> one_pulse(o_clear_count))
		else $error("clear count pulse wrong");
	chk_clr_chan_pulse: assert property (xa_wr ##0 i_reg_wdata[1] |=> one_pulse(o_clear_channel))
		else $error("clear channel pulse wrong");
	chk_cfg_timer_en: assert property (xa_wr |-> ##2 o_event_timer_en == $past(i_reg_wdata[2], 2))
		else $error("event timer enable wrong");
	chk_pio_blocked: assert property ((i_latch_wr || i_latch_rd) && (i_bus_dma_enable || i_bus_transfer_enable)
		|=> !o_pio_start) else $error("pio started under dma");
	chk_pio_cause: assert property (o_pio_start |-> $past(i_latch_wr) || $past(i_latch_rd))
		else $error("pio start without access");
	chk_reset_out: assert property (i_ce && i_reg_wr && i_reg_addr == 8'h00 && i_reg_wdata[0]
		|-> ##[1:2] o_bus.rst) else $error("bus reset not driven");
	chk_timeout_sel: assert property ($rose(o_status.sel_timeout) |-> ##[0:1] !o_bus.sel)
		else $error("sel held after timeout");
	chk_sel_in_sticky: assert property (o_status.selected_in && !i_status_clear.selected_in
		|=> o_status.selected_in) else $error("selected flag lost");
endmodule
bind seq_xfer_ctl seq_xfer_ctl_checker i_chk (.i_ref_clk, .i_rst, .i_ce, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
	.i_latch_wr, .i_latch_rd, .i_bus_dma_enable, .i_bus_transfer_enable, .i_status_clear, .o_bus, .o_status,
	.o_pio_start, .o_clear_count, .o_clear_channel, .o_event_timer_en);
`default_nettype wire

// ### dv/seq_xfer_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module seq_xfer_ctl_tb;
	logic i_ref_clk = 0, i_rst = 1, i_ce = 1, i_reg_wr = 0, i_reg_rd = 0, i_latch_wr = 0, i_latch_rd = 0;
	logic i_clear_attention = 0, i_rate_slow = 0, i_bus_dma_enable = 0, i_bus_transfer_enable = 0;
	logic i_parity_err = 0, i_phase_in = 0, i_bus_sel = 0, i_bus_req = 0, i_bus_ack = 0, i_bus_rst = 0;
	logic i_sel_valid = 0, i_resel_valid = 0, i_bus_bsy, answer = 0, rd_d = 0, rq = 0, ak = 0;
	logic o_req_filt, o_ack_filt, o_pio_start, o_clear_count, o_clear_channel, o_event_timer_en;
	logic [7:0] i_reg_addr = '0, i_reg_wdata = '0, o_reg_rdata, o_latch_data, v, ex;
	logic [3:0] dly = '0;
	seq_xfer_pkg::status_t i_status_clear = '0, o_status;
	seq_xfer_pkg::bus_out_t i_direct = '0, o_bus;
	int bad_count = 0, n_tests = 0;
	logic [7:0] q[$];
	seq_xfer_ctl #(.ARB_CYCLES(4), .SEL_TO_BASE(20)) i_dut (.*);
	bus_target_model i_tgt (.i_clk(i_ref_clk), .i_rst(i_rst), .i_sel(o_bus.sel), .i_answer(answer),
		.i_delay(dly), .o_bsy(i_bus_bsy));
	initial begin
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end
	task cyc;
		@(posedge i_ref_clk);
		#2;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task f(input string n, input logic e, input logic s);
		chk(n, {7'h00, e}, {7'h00, s});
	endtask
	// Host writes only while both DMA enables are low
	task wr(input logic [7:0] a, input logic [7:0] d);
		cyc;
		i_reg_wr = 1;
		i_reg_addr = a;
		i_reg_wdata = d;
		cyc;
		i_reg_wr = 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		cyc;
		i_reg_rd = 1;
		i_reg_addr = a;
		q.push_back(e);
		cyc;
		i_reg_rd = 0;
	endtask
	task sclr;
		i_status_clear = '1;
		cyc;
		i_status_clear = '0;
	endtask
	task end_sim;
		if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Read data lands one cycle after the read strobe is taken
	always @(posedge i_ref_clk) begin
		if (rd_d) begin
			ex = q.pop_front();
			chk("rdata", ex, o_reg_rdata);
		end
		rd_d <= i_reg_rd;
	end
	// Watchdog against a hung wait
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		bad_count++;
		end_sim;
	end
	initial begin
		v = 8'($urandom(32'h478394d1));
		repeat (10) @(posedge i_ref_clk);
		#2 i_rst = 0;
		// Reset values, unmapped offset reads zero
		for (int a = 0; a < 4; a++) rd(8'(a), 8'h00);
		repeat (4) begin
			v = 8'($urandom);
			wr(seq_xfer_pkg::ADDR_XA, v);
			rd(seq_xfer_pkg::ADDR_XA, v & seq_xfer_pkg::XA_STORE_MASK);
			f("timer_en", v[2], o_event_timer_en);
		end
		wr(seq_xfer_pkg::ADDR_XA, 8'h00);
		// Bus reset keeps only reset-out
		v = 8'($urandom) & 8'hbf;
		wr(seq_xfer_pkg::ADDR_SEQ, v);
		rd(seq_xfer_pkg::ADDR_SEQ, v);
		f("rst_out", v[0], o_bus.rst);
		i_bus_rst = 1;
		repeat (6) cyc;
		rd(seq_xfer_pkg::ADDR_SEQ, v & 8'h01);
		i_bus_rst = 0;
		repeat (6) cyc;
		wr(seq_xfer_pkg::ADDR_SEQ, 8'h00);
		// Outbound selection, then reselection; target answers
		wr(seq_xfer_pkg::ADDR_XB, 8'h1c);
		for (int r = 0; r < 2; r++) begin
			answer = 1;
			dly = 4'($urandom % 8);
			wr(seq_xfer_pkg::ADDR_SEQ, r ? 8'hc0 : 8'h48);
			for (int i = 0; i < 200 && o_status.sel_done !== 1'b1; i++) cyc;
			f("done", 1, o_status.sel_done);
			f("role", r[0], o_status.target_role);
			f("atn", !r[0], o_bus.atn);
			wr(seq_xfer_pkg::ADDR_SEQ, 8'h00);
			f("atn_hold", !r[0], o_bus.atn);
			i_clear_attention = 1;
			cyc;
			i_clear_attention = 0;
			cyc;
			f("atn_clr", 0, o_bus.atn);
			sclr;
			answer = 0;
			repeat (6) cyc;
		end
		// No answer: hardware timeout, then reset suppressed by auto-config
		wr(seq_xfer_pkg::ADDR_SEQ, 8'h40);
		for (int i = 0; i < 40 && o_bus.sel !== 1'b1; i++) cyc;
		f("in_prog", 1, o_status.sel_in_progress);
		for (int i = 0; i < 400 && o_status.sel_timeout !== 1'b1; i++) cyc;
		f("timeout", 1, o_status.sel_timeout);
		cyc;
		f("sel_off", 0, o_bus.sel);
		f("in_prog_off", 0, o_status.sel_in_progress);
		repeat (2) cyc;
		f("to_rst", 1, o_bus.rst);
		i_direct = 4'($urandom) & 4'he;
		wr(seq_xfer_pkg::ADDR_XA, 8'h04);
		repeat (3) cyc;
		f("to_rst_cfg", 0, o_bus.rst);
		chk("direct", {4'h0, i_direct}, {4'h0, o_bus});
		i_direct = '0;
		wr(seq_xfer_pkg::ADDR_XA, 8'h00);
		wr(seq_xfer_pkg::ADDR_SEQ, 8'h00);
		sclr;
		// Inbound selection, then reselection with auto attention
		for (int r = 0; r < 2; r++) begin
			wr(seq_xfer_pkg::ADDR_SEQ, r ? 8'h14 : 8'h20);
			i_bus_sel = 1;
			{i_resel_valid, i_sel_valid} = r ? 2'h2 : 2'h1;
			repeat (4) cyc;
			{i_resel_valid, i_sel_valid} = 2'h0;
			for (int i = 0; i < 20 && o_status.selected_in !== 1'b1; i++) cyc;
			cyc;
			f("sel_in", 1, o_status.selected_in);
			f("role_in", !r[0], o_status.target_role);
			f("atn_in", r[0], o_bus.atn);
			i_bus_sel = 0;
			wr(seq_xfer_pkg::ADDR_SEQ, 8'h00);
			sclr;
		end
		// Two-cycle REQ passes all but the expanded slow filter; three-cycle ACK always passes
		for (int m = 0; m < 4; m++) begin
			i_rate_slow = m[1];
			wr(seq_xfer_pkg::ADDR_XA, {m != 0, m == 3, 6'h00});
			{i_bus_req, i_bus_ack} = 2'h3;
			repeat (2) cyc;
			i_bus_req = 0;
			cyc;
			i_bus_ack = 0;
			{rq, ak} = 2'h0;
			repeat (10) begin
				cyc;
				rq = rq | o_req_filt;
				ak = ak | o_ack_filt;
			end
			f("req_filt", m != 3, rq);
			f("ack_filt", 1, ak);
		end
		// Parity error in an input phase raises attention only with checking on
		wr(seq_xfer_pkg::ADDR_SEQ, 8'h02);
		i_bus_sel = 1;
		for (int p = 0; p < 2; p++) begin
			wr(seq_xfer_pkg::ADDR_XB, p ? 8'h20 : 8'h00);
			{i_parity_err, i_phase_in} = 2'h3;
			cyc;
			i_parity_err = 0;
			cyc;
			f("atn_par", p[0], o_bus.atn);
		end
		// Clock enable low blocks a write to control B
		i_ce = 0;
		wr(seq_xfer_pkg::ADDR_XB, 8'($urandom));
		i_ce = 1;
		rd(seq_xfer_pkg::ADDR_XB, 8'h20);
		i_bus_sel = 0;
		i_phase_in = 0;
		wr(seq_xfer_pkg::ADDR_SEQ, 8'h00);
		// Data latch accesses with enables that block PIO
		wr(seq_xfer_pkg::ADDR_XA, 8'h08);
		repeat (8) begin
			v = 8'($urandom);
			{i_bus_dma_enable, i_bus_transfer_enable, i_rate_slow, i_bus_req, i_bus_ack, i_phase_in} = v[5:0];
			i_latch_wr = v[6];
			i_latch_rd = !v[6];
			i_reg_wdata = v;
			cyc;
			i_latch_wr = 0;
			i_latch_rd = 0;
			f("pio", !(v[5] | v[4]), o_pio_start);
			if (v[6]) chk("latch", v, o_latch_data);
			cyc;
		end
		repeat (3) cyc;
		end_sim;
	end
endmodule
`default_nettype wire
